//--- verilog/rso_defs.svh
`ifndef RSO_DEFS_SVH
`define RSO_DEFS_SVH

// table geometry
`define RSO_ENTRIES 8
`define RSO_ENT_W 3
`define RSO_USAGE_BYTES 16
`define RSO_USAGE_AW 4

// register byte addresses
`define RSO_ADDR_CTRL 8'h00
`define RSO_ADDR_SEL 8'h04
`define RSO_ADDR_CFG 8'h08
`define RSO_ADDR_NOM 8'h0C
`define RSO_ADDR_REC 8'h10
`define RSO_ADDR_UADDR 8'h14
`define RSO_ADDR_UDATA 8'h18
`define RSO_ADDR_STATUS 8'h1C

// control register fields
`define RSO_CTRL_AVAIL 0
`define RSO_CTRL_DEFER 1
`define RSO_CTRL_MODE_HI 15
`define RSO_CTRL_MODE_LO 8

// entry config fields
`define RSO_CFG_OP_HI 7
`define RSO_CFG_OP_LO 0
`define RSO_CFG_VALID 8
`define RSO_CFG_VENDOR 9
`define RSO_CFG_LEN_HI 14
`define RSO_CFG_LEN_LO 10
`define RSO_CFG_CS_HI 23
`define RSO_CFG_CS_LO 16

// request and response codes
`define RSO_ROPT_ONE 3'h1
`define RSO_SUP_UNAVAIL 3'h0
`define RSO_SUP_NONE 3'h1
`define RSO_SUP_STD 3'h3
`define RSO_SUP_VENDOR 3'h5

// response layout
`define RSO_HDR_BYTES 6'h04
`define RSO_TD_BYTES 6'h0C
`define RSO_TD_LEN 8'h0A
`define RSO_IDX_FLAGS 6'h01
`define RSO_IDX_SIZE_HI 6'h02
`define RSO_IDX_SIZE_LO 6'h03
`define RSO_TD_IDX_LEN_LO 4'h1
`define RSO_TD_IDX_CS 4'h3
`define RSO_TD_IDX_NOM 4'h4
`define RSO_TD_IDX_REC 4'h8
`define RSO_TIMEOUT_DESCRIPTOR_PRESENT_BIT 7

// buffer-write command and microcode modes
`define RSO_OP_WBUF 8'h3B
`define RSO_WB_DL 8'h04
`define RSO_WB_DL_SAVE 8'h05
`define RSO_WB_DL_OFS 8'h06
`define RSO_WB_DL_OFS_SAVE 8'h07
`define RSO_WB_DL_DEFER 8'h0E
`define RSO_WB_ACTIVATE 8'h0F

`endif

//--- verilog/rso_pkg.sv
`include "rso_defs.svh"

package rso_pkg;

    typedef enum logic [1:0] {
        RSO_IDLE,
        RSO_SEND,
        RSO_DRAIN
    } rso_state_e;

    typedef struct packed {
        rso_state_e st;
        logic info_avail;
        logic defer_evt;
        logic [7:0] wb_mode;
        logic [`RSO_ENT_W-1:0] sel;
        logic [`RSO_USAGE_AW-1:0] uaddr;
        logic [`RSO_ENTRIES-1:0][7:0] opc;
        logic [`RSO_ENTRIES-1:0] ent_valid;
        logic [`RSO_ENTRIES-1:0] vendor;
        logic [`RSO_ENTRIES-1:0][4:0] clen;
        logic [`RSO_ENTRIES-1:0][7:0] csb;
        logic [`RSO_ENTRIES-1:0][31:0] nom;
        logic [`RSO_ENTRIES-1:0][31:0] rec;
        logic [`RSO_ENTRIES-1:0][`RSO_USAGE_BYTES-1:0][7:0] usage;
        logic [`RSO_ENT_W-1:0] cur;
        logic [2:0] sup;
        logic tdp;
        logic [5:0] tot;
        logic [5:0] idx;
        logic [31:0] alloc;
        logic [7:0] req_cnt;
        logic [31:0] rd_data;
        logic out_valid;
        logic [7:0] out_data;
        logic out_last;
        logic req_err;
        logic done;
        logic busy;
    } rso_state_s;

endpackage : rso_pkg

//--- verilog/rso_byte_pick.sv
`timescale 1ns/1ns
`default_nettype none

module rso_byte_pick
    import rso_pkg::*;
(
    input wire logic [31:0] word,
    input wire logic [1:0] sel,
    output logic [7:0] byte_out
);

    // most significant byte goes out first
    always_comb begin
        case (sel)
            2'h0: byte_out = word[31:24];
            2'h1: byte_out = word[23:16];
            2'h2: byte_out = word[15:8];
            default: byte_out = word[7:0];
        endcase
    end

endmodule : rso_byte_pick

`default_nettype wire

//--- verilog/rso_report.sv
// Strobed register access and the register offsets were decided locally.

`timescale 1ns/1ns
`default_nettype none
`include "rso_defs.svh"

module rso_report
    import rso_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire logic [2:0] req_ropts,
    input wire logic req_timeout_descriptor_request,
    input wire logic [7:0] req_opcode,
    input wire logic [31:0] req_alloc,
    output logic req_busy,
    output logic req_err,
    output logic req_done,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic out_ready
);

    rso_state_s s_reg;
    rso_state_s s_next;

    logic hit;
    logic [`RSO_ENT_W-1:0] hit_idx;
    logic [4:0] cur_len;
    logic [5:0] use_off;
    logic [5:0] td_off;
    logic [7:0] cs_out;
    logic mode_ok;
    logic [7:0] nom_byte;
    logic [7:0] rec_byte;
    logic [7:0] byte_val;
    logic [5:0] lim;
    logic [5:0] req_tot;
    logic [2:0] req_sup;
    logic emit;
    logic last_now;

    // table lookup of the requested opcode
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < `RSO_ENTRIES; i++) begin
            if (s_reg.ent_valid[i] && s_reg.opc[i] == req_opcode
                    && !hit) begin
                hit = 1'b1;
                hit_idx = `RSO_ENT_W'(i);
            end
        end
    end

    // support code and response length for a new request
    always_comb begin
        if (!s_reg.info_avail) begin
            req_sup = `RSO_SUP_UNAVAIL;
        end else if (!hit) begin
            req_sup = `RSO_SUP_NONE;
        end else if (s_reg.vendor[hit_idx]) begin
            req_sup = `RSO_SUP_VENDOR;
        end else begin
            req_sup = `RSO_SUP_STD;
        end
        req_tot = `RSO_HDR_BYTES;
        if (req_sup == `RSO_SUP_STD || req_sup == `RSO_SUP_VENDOR) begin
            req_tot = `RSO_HDR_BYTES + {1'b0, s_reg.clen[hit_idx]}
                + (req_timeout_descriptor_request ? `RSO_TD_BYTES : 6'h00);
        end
    end

    assign cur_len = (s_reg.sup == `RSO_SUP_STD
        || s_reg.sup == `RSO_SUP_VENDOR) ? s_reg.clen[s_reg.cur] : 5'h00;
    assign use_off = s_reg.idx - `RSO_HDR_BYTES;
    assign td_off = use_off - {1'b0, cur_len};

    always_comb begin
        case (s_reg.wb_mode)
            `RSO_WB_DL: mode_ok = 1'b1;
            `RSO_WB_DL_SAVE: mode_ok = 1'b1;
            `RSO_WB_DL_OFS: mode_ok = 1'b1;
            `RSO_WB_DL_OFS_SAVE: mode_ok = 1'b1;
            `RSO_WB_ACTIVATE: mode_ok = 1'b1;
            `RSO_WB_DL_DEFER: mode_ok = s_reg.defer_evt;
            default: mode_ok = 1'b0;
        endcase
    end

    // reserved unless buffer-write in a listed mode
    // stored zero means no stated maximum
    assign cs_out = (s_reg.opc[s_reg.cur] == `RSO_OP_WBUF && mode_ok)
        ? s_reg.csb[s_reg.cur] : 8'h00;

    rso_byte_pick u_nom (
        .word(s_reg.nom[s_reg.cur]),
        .sel(td_off[1:0]),
        .byte_out(nom_byte)
    );

    rso_byte_pick u_rec (
        .word(s_reg.rec[s_reg.cur]),
        .sel(td_off[1:0]),
        .byte_out(rec_byte)
    );

    // response byte at the current index
    always_comb begin
        byte_val = 8'h00;
        if (s_reg.idx == `RSO_IDX_FLAGS) begin
            byte_val = {s_reg.tdp, 4'h0, s_reg.sup};
            byte_val[`RSO_TIMEOUT_DESCRIPTOR_PRESENT_BIT] = s_reg.tdp;
        end else if (s_reg.idx == `RSO_IDX_SIZE_HI) begin
            byte_val = 8'h00;
        end else if (s_reg.idx == `RSO_IDX_SIZE_LO) begin
            byte_val = {3'h0, cur_len};
        end else if (s_reg.idx >= `RSO_HDR_BYTES
                && use_off < {1'b0, cur_len}) begin
            if (use_off == 6'h00) begin
                byte_val = s_reg.opc[s_reg.cur];
            end else begin
                byte_val = s_reg.usage[s_reg.cur][use_off[`RSO_USAGE_AW-1:0]];
            end
        end else if (s_reg.idx >= `RSO_HDR_BYTES) begin
            if (td_off[3:0] == `RSO_TD_IDX_LEN_LO) begin
                byte_val = `RSO_TD_LEN;
            end else if (td_off[3:0] == `RSO_TD_IDX_CS) begin
                byte_val = cs_out;
            end else if (td_off[3:0] >= `RSO_TD_IDX_REC) begin
                byte_val = rec_byte;
            end else if (td_off[3:0] >= `RSO_TD_IDX_NOM) begin
                byte_val = nom_byte;
            end else begin
                byte_val = 8'h00;
            end
        end
    end

    // truncate to the allocation length
    assign lim = (s_reg.alloc < {26'h0, s_reg.tot})
        ? s_reg.alloc[5:0] : s_reg.tot;
    assign emit = s_reg.st == RSO_SEND && (!s_reg.out_valid || out_ready);
    assign last_now = (s_reg.idx + 6'h01) == lim;

    always_comb begin
        s_next = s_reg;
        s_next.req_err = 1'b0;
        s_next.done = 1'b0;
        s_next.rd_data = 32'h0000_0000;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                `RSO_ADDR_CTRL: begin
                    s_next.info_avail = reg_wdata[`RSO_CTRL_AVAIL];
                    s_next.defer_evt = reg_wdata[`RSO_CTRL_DEFER];
                    s_next.wb_mode =
                        reg_wdata[`RSO_CTRL_MODE_HI:`RSO_CTRL_MODE_LO];
                end
                `RSO_ADDR_SEL: s_next.sel = reg_wdata[`RSO_ENT_W-1:0];
                `RSO_ADDR_CFG: begin
                    s_next.opc[s_reg.sel] =
                        reg_wdata[`RSO_CFG_OP_HI:`RSO_CFG_OP_LO];
                    s_next.ent_valid[s_reg.sel] = reg_wdata[`RSO_CFG_VALID];
                    s_next.vendor[s_reg.sel] = reg_wdata[`RSO_CFG_VENDOR];
                    s_next.clen[s_reg.sel] =
                        reg_wdata[`RSO_CFG_LEN_HI:`RSO_CFG_LEN_LO];
                    s_next.csb[s_reg.sel] =
                        reg_wdata[`RSO_CFG_CS_HI:`RSO_CFG_CS_LO];
                end
                `RSO_ADDR_NOM: s_next.nom[s_reg.sel] = reg_wdata;
                `RSO_ADDR_REC: s_next.rec[s_reg.sel] = reg_wdata;
                `RSO_ADDR_UADDR: s_next.uaddr = reg_wdata[`RSO_USAGE_AW-1:0];
                `RSO_ADDR_UDATA: begin
                    s_next.usage[s_reg.sel][s_reg.uaddr] = reg_wdata[7:0];
                    s_next.uaddr = s_reg.uaddr + `RSO_USAGE_AW'(1);
                end
                default: s_next.sel = s_reg.sel;
            endcase
        end

        // register reads, data one cycle later
        if (reg_rd) begin
            case (reg_addr)
                `RSO_ADDR_CTRL: begin
                    s_next.rd_data[`RSO_CTRL_AVAIL] = s_reg.info_avail;
                    s_next.rd_data[`RSO_CTRL_DEFER] = s_reg.defer_evt;
                    s_next.rd_data[`RSO_CTRL_MODE_HI:`RSO_CTRL_MODE_LO] =
                        s_reg.wb_mode;
                end
                `RSO_ADDR_SEL: s_next.rd_data[`RSO_ENT_W-1:0] = s_reg.sel;
                `RSO_ADDR_CFG: begin
                    s_next.rd_data[`RSO_CFG_OP_HI:`RSO_CFG_OP_LO] =
                        s_reg.opc[s_reg.sel];
                    s_next.rd_data[`RSO_CFG_VALID] =
                        s_reg.ent_valid[s_reg.sel];
                    s_next.rd_data[`RSO_CFG_VENDOR] = s_reg.vendor[s_reg.sel];
                    s_next.rd_data[`RSO_CFG_LEN_HI:`RSO_CFG_LEN_LO] =
                        s_reg.clen[s_reg.sel];
                    s_next.rd_data[`RSO_CFG_CS_HI:`RSO_CFG_CS_LO] =
                        s_reg.csb[s_reg.sel];
                end
                `RSO_ADDR_NOM: s_next.rd_data = s_reg.nom[s_reg.sel];
                `RSO_ADDR_REC: s_next.rd_data = s_reg.rec[s_reg.sel];
                `RSO_ADDR_UADDR:
                    s_next.rd_data[`RSO_USAGE_AW-1:0] = s_reg.uaddr;
                `RSO_ADDR_UDATA:
                    s_next.rd_data[7:0] = s_reg.usage[s_reg.sel][s_reg.uaddr];
                `RSO_ADDR_STATUS: begin
                    s_next.rd_data[0] = s_reg.busy;
                    s_next.rd_data[6:4] = s_reg.sup;
                    s_next.rd_data[7] = s_reg.tdp;
                    s_next.rd_data[15:8] = s_reg.req_cnt;
                end
                default: s_next.rd_data = 32'h0000_0000;
            endcase
        end

        case (s_reg.st)
            RSO_IDLE: begin
                if (req_valid) begin
                    if (req_ropts != `RSO_ROPT_ONE) begin
                        s_next.req_err = 1'b1;
                    end else begin
                        s_next.cur = hit_idx;
                        s_next.sup = req_sup;
                        s_next.tot = req_tot;
                        s_next.tdp = req_timeout_descriptor_request && (req_sup == `RSO_SUP_STD
                            || req_sup == `RSO_SUP_VENDOR);
                        s_next.alloc = req_alloc;
                        s_next.idx = 6'h00;
                        s_next.req_cnt = s_reg.req_cnt + 8'h01;
                        if (req_alloc == 32'h0000_0000) begin
                            s_next.done = 1'b1;
                        end else begin
                            s_next.st = RSO_SEND;
                            s_next.busy = 1'b1;
                        end
                    end
                end
            end
            RSO_SEND: begin
                if (emit) begin
                    s_next.out_valid = 1'b1;
                    s_next.out_data = byte_val;
                    s_next.out_last = last_now;
                    s_next.idx = s_reg.idx + 6'h01;
                    if (last_now) begin
                        s_next.st = RSO_DRAIN;
                    end
                end
            end
            RSO_DRAIN: begin
                if (out_ready) begin
                    s_next.out_valid = 1'b0;
                    s_next.out_last = 1'b0;
                    s_next.done = 1'b1;
                    s_next.busy = 1'b0;
                    s_next.st = RSO_IDLE;
                end
            end
            default: s_next.st = RSO_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.st <= RSO_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rd_data;
    assign req_busy = s_reg.busy;
    assign req_err = s_reg.req_err;
    assign req_done = s_reg.done;
    assign out_valid = s_reg.out_valid;
    assign out_data = s_reg.out_data;
    assign out_last = s_reg.out_last;

endmodule : rso_report

`default_nettype wire

//--- dv/rso_report_sva.sv
`timescale 1ns/1ns
`default_nettype none

module rso_report_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire logic [2:0] req_ropts,
    input wire logic req_timeout_descriptor_request,
    input wire logic [7:0] req_opcode,
    input wire logic [31:0] req_alloc,
    input wire logic req_busy,
    input wire logic req_err,
    input wire logic req_done,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic out_ready
);
    typedef struct packed {
        logic [5:0] idx;
        logic [2:0] sup;
        logic flag;
        logic [4:0] len;
    } rso_chk_s;
    rso_chk_s chk_reg;
    rso_chk_s chk_next;
    logic idle_in;
    assign idle_in = req_valid && !req_busy && !req_done;
    // byte position tracker of the response stream
    always_comb begin
        chk_next = chk_reg;
        if (out_valid && out_ready)
            chk_next.idx = chk_reg.idx + 6'h01;
        if (out_valid && chk_reg.idx == 6'h01) begin
            chk_next.sup = out_data[2:0];
            chk_next.flag = out_data[7];
        end
        if (out_valid && chk_reg.idx == 6'h03)
            chk_next.len = out_data[4:0];
        if (req_done)
            chk_next = '0;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            chk_reg <= '0;
        else
            chk_reg <= chk_next;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        idle_in && req_ropts == 3'h1 && req_alloc != 32'h0;
    endsequence
    sequence s_first;
        ##1 req_busy ##1 (out_valid && out_data == 8'h00);
    endsequence
    a_first_byte: assert property (s_take |-> s_first)
        else $error("first response byte late or wrong");
    a_bad_opts: assert property (idle_in && req_ropts != 3'h1
        |=> req_err && !req_busy && !out_valid)
        else $error("bad options not refused");
    a_alloc_zero: assert property (idle_in && req_ropts == 3'h1
        && req_alloc == 32'h0 |=> req_done && !req_busy)
        else $error("zero length not finished at once");
    a_hold_stall: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("byte changed while stalled");
    a_last_done: assert property (out_valid && out_ready && out_last
        |=> req_done && !out_valid && !req_busy)
        else $error("no done after last byte");
    a_hdr_zero: assert property (out_valid && (chk_reg.idx == 6'h00
        || chk_reg.idx == 6'h02) |-> out_data == 8'h00)
        else $error("reserved header byte not zero");
    a_sup_legal: assert property (out_valid && chk_reg.idx == 6'h01
        |-> out_data[6:3] == 4'h0
        && out_data[2:0] inside {3'h0, 3'h1, 3'h3, 3'h5})
        else $error("reserved support code");
    a_flag_unsup: assert property (out_valid && chk_reg.idx == 6'h01
        && out_data[2:1] == 2'h0 |-> !out_data[7])
        else $error("descriptor flag on failed lookup");
    a_len_none: assert property (out_valid && chk_reg.idx == 6'h03
        && chk_reg.sup[2:1] == 2'h0 |-> out_data == 8'h00)
        else $error("size not zero on failed lookup");
    a_td_len: assert property (out_valid && chk_reg.flag
        && chk_reg.idx == {1'b0, chk_reg.len} + 6'h05
        |-> out_data == 8'h0A)
        else $error("descriptor length byte wrong");
    a_no_overrun: assert property (out_valid && chk_reg.idx > 6'h03
        |-> chk_reg.idx < {1'b0, chk_reg.len}
        + (chk_reg.flag ? 6'h10 : 6'h04))
        else $error("response longer than its size");
endmodule : rso_report_sva

bind rso_report rso_report_sva rso_report_sva_inst (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_ropts(req_ropts),
    .req_timeout_descriptor_request(req_timeout_descriptor_request), .req_opcode(req_opcode), .req_alloc(req_alloc),
    .req_busy(req_busy), .req_err(req_err), .req_done(req_done),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready)
);

`default_nettype wire

//--- dv/rso_initiator_model.sv
`timescale 1ns/1ns
`default_nettype none

module rso_initiator_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    output logic out_ready
);
    logic [7:0] rx_q [$];
    logic last_q [$];
    logic [1:0] ph;
    // takes one byte per handshake, stalls three of four cycles when slow
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ph <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            if (out_valid && out_ready) begin
                rx_q.push_back(out_data);
                last_q.push_back(out_last);
            end
            ph <= ph + 2'h1;
            out_ready <= !slow || (ph == 2'h3);
        end
    end
endmodule : rso_initiator_model

`default_nettype wire

//--- dv/rso_report_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "rso_defs.svh"

module rso_report_tb;
    typedef struct packed {
        logic [7:0] op;
        logic timeout_descriptor_request;
        logic [7:0] alloc;
        logic [15:0] ctrl;
        logic [2:0] sup;
        logic [7:0] cs;
        logic slow;
    } rso_row_s;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic req_valid = 1'b0;
    logic [2:0] req_ropts = 3'h0;
    logic req_timeout_descriptor_request = 1'b0;
    logic [7:0] req_opcode = 8'h00;
    logic [31:0] req_alloc = 32'h0;
    logic req_busy, req_err, req_done, out_valid, out_last, out_ready;
    logic [7:0] out_data;
    logic slow = 1'b0;
    logic got_err, got_done;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [7:0] exp_q [$];
    logic [7:0] t_op [2] = '{8'h12, 8'h3B};
    logic [4:0] t_len [2] = '{5'h06, 5'h0A};
    logic [31:0] t_nom [2] = '{32'h11223344, 32'h0A0B0C0D};
    logic [31:0] t_rec [2] = '{32'h55667788, 32'h01020304};
    rso_row_s rows [13] = '{
        '{8'h12, 1'b1, 8'h40, 16'h0000, 3'h0, 8'h00, 1'b0},
        '{8'h12, 1'b1, 8'h40, 16'h0001, 3'h3, 8'h00, 1'b1},
        '{8'h12, 1'b0, 8'h40, 16'h0001, 3'h3, 8'h00, 1'b0},
        '{8'h3B, 1'b1, 8'h40, 16'h0401, 3'h5, 8'h2A, 1'b1},
        '{8'h3B, 1'b1, 8'h40, 16'h0501, 3'h5, 8'h2A, 1'b0},
        '{8'h3B, 1'b1, 8'h40, 16'h0601, 3'h5, 8'h2A, 1'b0},
        '{8'h3B, 1'b1, 8'h40, 16'h0701, 3'h5, 8'h2A, 1'b0},
        '{8'h3B, 1'b1, 8'h40, 16'h0F01, 3'h5, 8'h2A, 1'b0},
        '{8'h3B, 1'b1, 8'h40, 16'h0E01, 3'h5, 8'h00, 1'b0},
        '{8'h3B, 1'b1, 8'h40, 16'h0E03, 3'h5, 8'h2A, 1'b1},
        '{8'h3B, 1'b1, 8'h40, 16'h0801, 3'h5, 8'h00, 1'b0},
        '{8'h77, 1'b1, 8'h40, 16'h0001, 3'h1, 8'h00, 1'b1},
        '{8'h12, 1'b1, 8'h05, 16'h0001, 3'h3, 8'h00, 1'b0}};

    rso_report rso_report_inst (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
        .req_ropts(req_ropts), .req_timeout_descriptor_request(req_timeout_descriptor_request), .req_opcode(req_opcode),
        .req_alloc(req_alloc), .req_busy(req_busy), .req_err(req_err),
        .req_done(req_done), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready));
    rso_initiator_model rso_initiator_model_inst (.core_clk(core_clk),
        .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

    always #25 core_clk = ~core_clk;

    function automatic logic [7:0] use_b(input int e, input int i);
        return {3'h4, e[0], i[3:0]};
    endfunction : use_b
    function automatic logic [31:0] cfg_w(input int e);
        return {8'h00, 8'h2A, 1'b0, t_len[e], e[0], 1'b1, t_op[e]};
    endfunction : cfg_w
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd
    task automatic do_req(input logic [7:0] op, input logic [2:0] ro,
            input logic td, input logic [31:0] al, input logic sl);
        int k;
        rso_initiator_model_inst.rx_q.delete();
        rso_initiator_model_inst.last_q.delete();
        @(posedge core_clk);
        slow <= sl;
        req_valid <= 1'b1;
        req_opcode <= op;
        req_ropts <= ro;
        req_timeout_descriptor_request <= td;
        req_alloc <= al;
        @(posedge core_clk);
        // a second request while busy, driven in slow rows only, must be dropped
        req_valid <= sl;
        req_opcode <= 8'h77;
        for (k = 0; k < 400; k++) begin
            #1;
            if (req_done === 1'b1 || req_err === 1'b1)
                break;
            @(posedge core_clk);
            req_valid <= 1'b0;
        end
        if (k == 400)
            check(32'h0, 32'h1);
        got_err = req_err;
        got_done = req_done;
    endtask : do_req
    task automatic build_exp(input rso_row_s r);
        int e;
        logic f;
        logic [4:0] n;
        e = (r.op == 8'h3B) ? 1 : 0;
        f = r.timeout_descriptor_request && (r.sup > 3'h1);
        n = (r.sup > 3'h1) ? t_len[e] : 5'h00;
        exp_q = '{8'h00, {f, 4'h0, r.sup}, 8'h00, {3'h0, n}};
        for (int i = 0; i < n; i++)
            exp_q.push_back(i == 0 ? r.op : use_b(e, i));
        if (f) begin
            exp_q = {exp_q, 8'h00, 8'h0A, 8'h00, r.cs};
            for (int j = 0; j < 8; j++)
                exp_q.push_back(j < 4 ? t_nom[e][8*(3-j) +: 8]
                                      : t_rec[e][8*(7-j) +: 8]);
        end
        while (exp_q.size() > r.alloc)
            void'(exp_q.pop_back());
    endtask : build_exp
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`RSO_ADDR_CFG, 32'h0);
        rd(`RSO_ADDR_CTRL, 32'h0);
        rd(8'h20, 32'h0);
        for (int e = 0; e < 2; e++) begin
            wr(`RSO_ADDR_SEL, 32'(e));
            wr(`RSO_ADDR_CFG, cfg_w(e));
            wr(`RSO_ADDR_NOM, t_nom[e]);
            wr(`RSO_ADDR_REC, t_rec[e]);
            wr(`RSO_ADDR_UADDR, 32'h0);
            for (int i = 0; i < 16; i++)
                wr(`RSO_ADDR_UDATA, {24'h0, use_b(e, i)});
            rd(`RSO_ADDR_CFG, cfg_w(e));
            rd(`RSO_ADDR_NOM, t_nom[e]);
            rd(`RSO_ADDR_UDATA, {24'h0, use_b(e, 0)});
        end
        // row table: support codes, descriptor, mode byte, truncation
        for (int r = 0; r < 13; r++) begin
            wr(`RSO_ADDR_CTRL, {16'h0, rows[r].ctrl});
            do_req(rows[r].op, 3'h1, rows[r].timeout_descriptor_request, 32'(rows[r].alloc),
                   rows[r].slow);
            build_exp(rows[r]);
            check(rso_initiator_model_inst.rx_q.size(), exp_q.size());
            for (int i = 0; i < exp_q.size(); i++) begin
                check(rso_initiator_model_inst.rx_q[i], exp_q[i]);
                check(rso_initiator_model_inst.last_q[i],
                      32'(i == exp_q.size() - 1));
            end
        end
        for (int ro = 0; ro < 8; ro++) begin
            if (ro != 1) begin
                do_req(8'h12, 3'(ro), 1'b1, 32'h40, 1'b0);
                check(got_err, 1'b1);
                check(rso_initiator_model_inst.rx_q.size(), 0);
            end
        end
        do_req(8'h12, 3'h1, 1'b1, 32'h0, 1'b0);
        check(got_done, 1'b1);
        check(rso_initiator_model_inst.rx_q.size(), 0);
        rd(`RSO_ADDR_STATUS, 32'h0000_0EB0);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`RSO_ADDR_CFG, 32'h0);
        rd(`RSO_ADDR_STATUS, 32'h0);
        report_and_stop();
    end
endmodule : rso_report_tb

`default_nettype wire
